// file: hdl/acsp_device.sv
// Converter end: conversion timing, power-down and serial slave
//
// Functional notes
// - Strobe level at conversion end picks mode
// - Host raises strobe early, waits quiet time
// - Strobe low at busy fall: power down
// - Strobe rising edge starts power-up
// - Host holds strobe low for power-up time
// - Five-wire slave, host clock, split data
// - Direction low writes, high reads
// - Direction rise shows MSB, falls shift
// - Ten bits MSB first, eight allowed
// - Direction stays high during whole read
// - Five-wire: direction low-high between reads
// - Five-wire output floats on deselect/direction fall
// - Control byte on first eight rises
// - Five-wire: direction high-low between writes
// - Works with select low, data tied
// - Three-wire: direction high drives MSB
// - Three-wire shifts from second falling edge
// - Three-wire pin released on direction fall
// - Three-wire: direction low-high between reads
// - Three-wire: direction high-low between writes
// - Strobe falling edge starts conversion
// - Busy lasts 9 or 27 us
`timescale 1ns/1ps
module acsp_device (
  input  wire logic                         clk_sys_i,
  input  wire logic                         resetn_i,
  input  wire logic                         three_wire_i,
  input  wire logic [acsp_pkg::RES_W-1:0]   sample_i,
  output logic [acsp_pkg::CTRL_W-1:0]       control_o,
  output logic                              powered_down_o,
  output logic                              normal_mode_o,
  acsp_if.dev                               link
);
  typedef struct packed {
    logic [1:0]                    cs_s;
    logic [1:0]                    cv_s;
    logic [1:0]                    ck_s;
    logic [1:0]                    rw_s;
    logic [1:0]                    di_s;
    logic                          cv_q;
    logic                          ck_q;
    logic                          rw_q;
    logic [acsp_pkg::CNT_W-1:0]    conv_cnt;
    logic                          busy;
    logic [acsp_pkg::RES_W-1:0]    sample;
    logic [acsp_pkg::RES_W-1:0]    result;
    logic [acsp_pkg::RES_W-1:0]    shreg;
    logic [3:0]                    fall_cnt;
    logic [3:0]                    wr_cnt;
    logic [acsp_pkg::CTRL_W-1:0]   ctrl_sh;
    logic [acsp_pkg::CTRL_W-1:0]   ctrl;
    logic                          pd;
    logic                          normal;
    logic                          dout;
    logic                          dout_oe;
    logic                          dio_oe;
  } acsp_dev_t;

  acsp_dev_t st_reg;
  acsp_dev_t st_next;

  logic cs_n_l;
  logic cv_l;
  logic ck_l;
  logic rw_l;
  logic di_l;
  logic cv_fall;
  logic cv_rise;
  logic ck_rise;
  logic ck_fall;
  logic rw_rise;
  logic rw_fall;
  logic sel;
  logic conv_done;

  assign cs_n_l    = st_reg.cs_s[1];
  assign cv_l      = st_reg.cv_s[1];
  assign ck_l      = st_reg.ck_s[1];
  assign rw_l      = st_reg.rw_s[1];
  assign di_l      = st_reg.di_s[1];
  assign cv_fall   = st_reg.cv_q && !cv_l;
  assign cv_rise   = !st_reg.cv_q && cv_l;
  assign ck_rise   = !st_reg.ck_q && ck_l;
  assign ck_fall   = st_reg.ck_q && !ck_l;
  assign rw_rise   = !st_reg.rw_q && rw_l;
  assign rw_fall   = st_reg.rw_q && !rw_l;
  // Three-wire form has no select pin; treat as selected
  assign sel       = three_wire_i || !cs_n_l;
  assign conv_done = st_reg.busy &&
                     (st_reg.conv_cnt == acsp_pkg::CNT_W'(1));

  always_comb begin
    st_next = st_reg;
    st_next.cs_s = {st_reg.cs_s[0], link.cs_n};
    st_next.cv_s = {st_reg.cv_s[0], link.conversion_start_n};
    st_next.ck_s = {st_reg.ck_s[0], link.sclk};
    st_next.rw_s = {st_reg.rw_s[0], link.rd_wr};
    st_next.di_s = {st_reg.di_s[0],
                    three_wire_i ? link.dio_wire : link.din};
    st_next.cv_q = cv_l;
    st_next.ck_q = ck_l;
    st_next.rw_q = rw_l;

    // Conversion engine
    if (cv_fall && !st_reg.busy) begin
      st_next.busy   = 1'b1;
      st_next.pd     = 1'b0;
      st_next.sample = sample_i;
      if (st_reg.ctrl[acsp_pkg::CTRL_W-1:acsp_pkg::CHAN_LSB] ==
          acsp_pkg::TEMP_CHAN) begin
        st_next.conv_cnt = acsp_pkg::CNT_W'(acsp_pkg::CONV_TEMP_CYC);
      end else begin
        st_next.conv_cnt = acsp_pkg::CNT_W'(acsp_pkg::CONV_ANALOG_CYC);
      end
    end else if (st_reg.busy) begin
      st_next.conv_cnt = st_reg.conv_cnt - acsp_pkg::CNT_W'(1);
      if (conv_done) begin
        st_next.busy   = 1'b0;
        st_next.result = st_reg.sample;
        st_next.normal = cv_l;
        st_next.pd     = !cv_l;
      end
    end
    if (st_reg.pd && cv_rise) begin
      st_next.pd = 1'b0;
    end

    // Serial port: read path
    if (rw_rise && sel) begin
      st_next.shreg    = st_reg.result;
      st_next.dout     = st_reg.result[acsp_pkg::RES_W-1];
      st_next.fall_cnt = 4'h0;
      st_next.dout_oe  = !three_wire_i;
      st_next.dio_oe   = three_wire_i;
    end else if (rw_l && sel && ck_fall &&
                 (st_reg.dout_oe || st_reg.dio_oe)) begin
      if (st_reg.fall_cnt != 4'hf) begin
        st_next.fall_cnt = st_reg.fall_cnt + 4'h1;
      end
      // Three-wire holds MSB over the first falling edge
      if (!three_wire_i || st_reg.fall_cnt != 4'h0) begin
        st_next.shreg = {st_reg.shreg[acsp_pkg::RES_W-2:0], 1'b0};
        st_next.dout  = st_reg.shreg[acsp_pkg::RES_W-2];
      end
    end
    if (rw_fall || (!three_wire_i && cs_n_l)) begin
      st_next.dout_oe = 1'b0;
    end
    if (rw_fall || !three_wire_i) begin
      st_next.dio_oe = 1'b0;
    end

    // Serial port: write path
    if (rw_fall) begin
      st_next.wr_cnt = 4'h0;
    end else if (!rw_l && sel && ck_rise &&
                 st_reg.wr_cnt != acsp_pkg::BITS_CTRL) begin
      st_next.ctrl_sh = {st_reg.ctrl_sh[acsp_pkg::CTRL_W-2:0], di_l};
      st_next.wr_cnt  = st_reg.wr_cnt + 4'h1;
      if (st_reg.wr_cnt == acsp_pkg::BITS_CTRL - 4'h1) begin
        st_next.ctrl = {st_reg.ctrl_sh[acsp_pkg::CTRL_W-2:0], di_l};
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg        <= '0;
      st_reg.cs_s   <= 2'h3;
      st_reg.cv_s   <= 2'h3;
      st_reg.rw_s   <= 2'h3;
      st_reg.rw_q   <= 1'b1;
      st_reg.cv_q   <= 1'b1;
      st_reg.normal <= 1'b1;
      // Write count saturated: no byte taken before a direction fall
      st_reg.wr_cnt <= acsp_pkg::BITS_CTRL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.busy       = st_reg.busy;
  assign link.dout_o     = st_reg.dout;
  assign link.dout_oe    = st_reg.dout_oe;
  assign link.dio_dev_o  = st_reg.dout;
  assign link.dio_dev_oe = st_reg.dio_oe;
  assign control_o       = st_reg.ctrl;
  assign powered_down_o  = st_reg.pd;
  assign normal_mode_o   = st_reg.normal;
endmodule

// file: hdl/acsp_host.sv
// Host end: starts conversions, reads results, writes control byte
`timescale 1ns/1ps
module acsp_host (
  input  wire logic                         clk_sys_i,
  input  wire logic                         resetn_i,
  input  wire logic                         three_wire_i,
  input  wire logic                         auto_pd_i,
  input  wire logic                         conv_req_i,
  input  wire logic                         read_req_i,
  input  wire logic                         read_short_i,
  input  wire logic                         write_req_i,
  input  wire logic [acsp_pkg::CTRL_W-1:0]  write_data_i,
  output logic                              idle_o,
  output logic                              rdata_valid_o,
  output logic [acsp_pkg::RES_W-1:0]        rdata_o,
  acsp_if.host                              link
);
  typedef enum logic [2:0] {
    HS_IDLE, HS_CONV_LOW, HS_CONV_WAIT, HS_XFER_SETUP, HS_XFER, HS_END,
    HS_QUIET
  } acsp_hst_t;

  typedef struct packed {
    acsp_hst_t                  state;
    logic [1:0]                 busy_s;
    logic [1:0]                 dat_s;
    logic [acsp_pkg::CNT_W-1:0] cnt;
    logic [3:0]                 bits;
    logic [3:0]                 nbits;
    logic                       is_read;
    logic                       cvst_n;
    logic                       sclk;
    logic                       rw;
    logic                       cs_n;
    logic                       dout;
    logic                       dio_oe;
    logic [acsp_pkg::RES_W-1:0] shreg;
    logic                       valid;
    logic                       idle;
    logic [acsp_pkg::RES_W-1:0] rdata;
  } acsp_host_t;

  acsp_host_t st_reg;
  acsp_host_t st_next;
  logic       din_l;

  assign din_l = st_reg.dat_s[1];

  always_comb begin
    st_next = st_reg;
    st_next.busy_s = {st_reg.busy_s[0], link.busy};
    st_next.dat_s  = {st_reg.dat_s[0],
                      three_wire_i ? link.dio_wire : link.dout_wire};
    st_next.valid  = 1'b0;
    if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - acsp_pkg::CNT_W'(1);
    end
    case (st_reg.state)
      HS_IDLE: begin
        if (conv_req_i) begin
          st_next.cvst_n = 1'b0;
          st_next.cnt    = acsp_pkg::CNT_W'(acsp_pkg::PWRUP_CYC);
          st_next.state  = HS_CONV_LOW;
        end else if (read_req_i || write_req_i) begin
          st_next.is_read = read_req_i;
          st_next.nbits   = read_short_i ? acsp_pkg::BITS_CTRL :
                            acsp_pkg::BITS_FULL;
          if (!read_req_i) begin
            st_next.nbits = acsp_pkg::BITS_CTRL;
          end
          // Three-wire read spends one extra clock on the MSB
          if (read_req_i && three_wire_i) begin
            st_next.nbits = st_next.nbits + 4'h1;
          end
          st_next.shreg  = {write_data_i, 2'h0};
          st_next.cs_n   = 1'b0;
          // Direction is parked opposite, giving a fresh edge
          st_next.rw     = !read_req_i;
          st_next.cnt    = acsp_pkg::CNT_W'(acsp_pkg::SCLK_HALF);
          st_next.state  = HS_XFER_SETUP;
        end
      end
      HS_CONV_LOW: begin
        // Normal mode raises before busy falls; auto mode waits
        if (st_reg.cnt == '0 && (!auto_pd_i || !st_reg.busy_s[1])) begin
          st_next.cvst_n = 1'b1;
          st_next.state  = HS_CONV_WAIT;
        end
      end
      HS_CONV_WAIT: begin
        if (!st_reg.busy_s[1]) begin
          st_next.state = HS_IDLE;
        end
      end
      HS_XFER_SETUP: begin
        if (st_reg.cnt == '0) begin
          st_next.rw     = st_reg.is_read;
          st_next.dio_oe = three_wire_i && !st_reg.is_read;
          st_next.bits   = 4'h0;
          if (st_reg.is_read) begin
            st_next.rdata = '0;
          end
          st_next.cnt    = acsp_pkg::CNT_W'(acsp_pkg::SCLK_HALF);
          st_next.dout   = st_reg.shreg[acsp_pkg::RES_W-1];
          st_next.state  = HS_XFER;
        end
      end
      HS_XFER: begin
        if (st_reg.cnt == '0) begin
          st_next.cnt  = acsp_pkg::CNT_W'(acsp_pkg::SCLK_HALF);
          st_next.sclk = !st_reg.sclk;
          if (st_reg.sclk) begin
            st_next.bits = st_reg.bits + 4'h1;
            st_next.dout = st_reg.shreg[acsp_pkg::RES_W-2];
            st_next.shreg = {st_reg.shreg[acsp_pkg::RES_W-2:0], 1'b0};
            if (st_reg.bits + 4'h1 == st_reg.nbits) begin
              st_next.state = HS_END;
            end
          end else if (st_reg.is_read &&
                       (!three_wire_i || st_reg.bits != 4'h0)) begin
            // Three-wire first rise precedes the non-shifting fall
            st_next.rdata = {st_reg.rdata[acsp_pkg::RES_W-2:0], din_l};
          end
        end
      end
      HS_END: begin
        if (st_reg.cnt == '0) begin
          st_next.rw     = !st_reg.is_read;
          st_next.cs_n   = 1'b1;
          st_next.dio_oe = 1'b0;
          st_next.valid  = st_reg.is_read;
          st_next.cnt    = acsp_pkg::CNT_W'(acsp_pkg::QUIET_CYC);
          st_next.state  = HS_QUIET;
        end
      end
      HS_QUIET: begin
        if (st_reg.cnt == '0) begin
          st_next.state = HS_IDLE;
        end
      end
      default: st_next.state = HS_IDLE;
    endcase
    st_next.idle = (st_next.state == HS_IDLE);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg        <= '0;
      st_reg.state  <= HS_IDLE;
      st_reg.cvst_n <= 1'b1;
      st_reg.cs_n   <= 1'b1;
      st_reg.rw     <= 1'b1;
      st_reg.idle   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.conversion_start_n = st_reg.cvst_n;
  assign link.sclk               = st_reg.sclk;
  assign link.rd_wr              = st_reg.rw;
  assign link.cs_n               = st_reg.cs_n;
  assign link.din                = st_reg.dout;
  assign link.dio_host_o         = st_reg.dout;
  assign link.dio_host_oe        = st_reg.dio_oe;
  assign idle_o        = st_reg.idle;
  assign rdata_valid_o = st_reg.valid;
  assign rdata_o       = st_reg.rdata;
endmodule

// file: hdl/acsp_if.sv
// Link between converter end and host end
`timescale 1ns/1ps
interface acsp_if;
  logic conversion_start_n;
  logic busy;
  logic sclk;
  logic rd_wr;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dio_dev_o;
  logic dio_dev_oe;
  logic dio_host_o;
  logic dio_host_oe;
  wire  dio_wire;
  logic dout_wire;
  // Resolved levels: five-wire din/dout; three-wire shared pin
  assign dio_wire  = dio_dev_oe ? dio_dev_o :
                     (dio_host_oe ? dio_host_o : 1'b1);
  assign dout_wire = dout_oe ? dout_o : 1'b1;
  modport dev (
    input  conversion_start_n,
    input  sclk,
    input  rd_wr,
    input  cs_n,
    input  din,
    input  dio_wire,
    output busy,
    output dout_o,
    output dout_oe,
    output dio_dev_o,
    output dio_dev_oe
  );
  modport host (
    output conversion_start_n,
    output sclk,
    output rd_wr,
    output cs_n,
    output din,
    output dio_host_o,
    output dio_host_oe,
    input  busy,
    input  dout_wire,
    input  dio_wire
  );
endinterface

// file: hdl/acsp_pkg.sv
// Shared constants for the converter control link
package acsp_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  localparam int unsigned CONV_ANALOG_US  = 9;
  localparam int unsigned CONV_TEMP_US    = 27;
  localparam int unsigned QUIET_NS        = 100;
  localparam int unsigned PWRUP_US        = 2;
  localparam int unsigned CONV_ANALOG_CYC =
    (CONV_ANALOG_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CONV_TEMP_CYC   =
    (CONV_TEMP_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned QUIET_CYC       =
    (QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PWRUP_CYC       =
    (PWRUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RES_W   = 10;
  localparam int unsigned CTRL_W  = 8;
  localparam int unsigned CNT_W   = 11;
  // Half period covers both synchronisers plus the output register
  localparam int unsigned SCLK_HALF = 5;
  localparam logic [3:0] BITS_FULL = 4'ha;
  localparam logic [3:0] BITS_CTRL = 4'h8;
  localparam logic [2:0] TEMP_CHAN = 3'h0;
  localparam int unsigned CHAN_LSB = 5;
endpackage

// file: testbench/acsp_link_asserts.sv
// Concurrent checks on the converter link signals
`timescale 1ns/1ps
module acsp_link_asserts (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic conversion_start_n,
  input wire logic busy,
  input wire logic sclk,
  input wire logic rd_wr,
  input wire logic cs_n,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dio_dev_o,
  input wire logic dio_dev_oe
);
  logic [11:0] busy_cnt_reg;
  logic [3:0]  fall_age_reg;
  // Busy length and cycles since strobe fall
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt_reg <= 12'h000;
      fall_age_reg <= 4'hf;
    end else begin
      busy_cnt_reg <= busy ? busy_cnt_reg + 12'h001 : 12'h000;
      if ($fell(conversion_start_n)) begin
        fall_age_reg <= 4'h0;
      end else if (fall_age_reg != 4'hf) begin
        fall_age_reg <= fall_age_reg + 4'h1;
      end
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  chk_busy_start: assert property (
    $fell(conversion_start_n) && !busy |-> ##[1:6] busy)
    else $error("Busy did not follow strobe fall");
  chk_busy_cause: assert property (
    $rose(busy) |-> fall_age_reg inside {[4'h1:4'h6]})
    else $error("Busy rose without recent strobe fall");
  chk_busy_len: assert property (
    $fell(busy) |-> busy_cnt_reg == acsp_pkg::CONV_ANALOG_CYC ||
                    busy_cnt_reg == acsp_pkg::CONV_TEMP_CYC)
    else $error("Busy length wrong");
  chk_rdwr_release: assert property (
    (!rd_wr) [*6] |-> !dout_oe && !dio_dev_oe)
    else $error("Data pin driven while direction low");
  chk_cs_release: assert property (
    cs_n [*6] ##0 !dio_dev_oe |-> !dout_oe)
    else $error("Data out driven while deselected");
  chk_drive_read: assert property (
    $rose(rd_wr) ##0 (rd_wr && !cs_n) [*6] |-> dout_oe || dio_dev_oe)
    else $error("No data driven on read");
  chk_dout_shift: assert property (
    dout_oe && $past(dout_oe) && $changed(dout_o) |-> !sclk)
    else $error("Data out changed while clock high");
  chk_dio_shift: assert property (
    dio_dev_oe && $past(dio_dev_oe) && $changed(dio_dev_o) |-> !sclk)
    else $error("Shared pin changed while clock high");
endmodule

// file: testbench/testbench.sv
// Self-checking bench joining converter end and host end
`timescale 1ns/1ps
module testbench;
  logic                        clk_sys_i;
  logic                        resetn_i;
  logic                        tw;
  logic                        auto_pd;
  logic                        conv_req;
  logic                        read_req;
  logic                        read_short;
  logic                        write_req;
  logic [acsp_pkg::CTRL_W-1:0] wdata;
  logic [acsp_pkg::RES_W-1:0]  sample;
  logic [acsp_pkg::CTRL_W-1:0] control;
  logic                        pdown;
  logic                        normal;
  logic                        idle;
  logic [acsp_pkg::RES_W-1:0]  rdata;
  logic                        rvalid;
  int                          errors;
  int                          total_checks;
  int                          cycles;
  int                          valid_cnt;
  acsp_if link ();
  acsp_device u_acsp_device (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .three_wire_i(tw), .sample_i(sample), .control_o(control),
    .powered_down_o(pdown), .normal_mode_o(normal), .link(link));
  acsp_host u_acsp_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .three_wire_i(tw), .auto_pd_i(auto_pd), .conv_req_i(conv_req),
    .read_req_i(read_req), .read_short_i(read_short),
    .write_req_i(write_req), .write_data_i(wdata), .idle_o(idle),
    .rdata_valid_o(rvalid), .rdata_o(rdata), .link(link));
  acsp_link_asserts u_acsp_link_asserts (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .conversion_start_n(link.conversion_start_n),
    .busy(link.busy), .sclk(link.sclk), .rd_wr(link.rd_wr),
    .cs_n(link.cs_n), .dout_o(link.dout_o), .dout_oe(link.dout_oe),
    .dio_dev_o(link.dio_dev_o), .dio_dev_oe(link.dio_dev_oe));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Counts read-data strobes from the host end
  always @(posedge clk_sys_i) begin
    if (rvalid === 1'b1) begin
      valid_cnt++;
    end
  end
  task automatic wrap_up();
    $display("Checks: %0d, errors: %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle request pulse: 0 conversion, 1 read, 2 write
  task automatic request(input int kind);
    @(posedge clk_sys_i);
    conv_req  <= (kind == 0);
    read_req  <= (kind == 1);
    write_req <= (kind == 2);
    @(posedge clk_sys_i);
    conv_req  <= 1'b0;
    read_req  <= 1'b0;
    write_req <= 1'b0;
  endtask
  task automatic wait_idle(output logic pd_seen);
    int n;
    n = 0;
    pd_seen = 1'b0;
    @(negedge clk_sys_i);
    while (idle !== 1'b1 && n < 4000) begin
      pd_seen = pd_seen | (pdown === 1'b1);
      @(negedge clk_sys_i);
      n++;
    end
    check(16'(n < 4000), 16'h0001);
  endtask
  task automatic do_write(input logic [7:0] data);
    logic pd;
    int   v;
    v = valid_cnt;
    @(posedge clk_sys_i);
    wdata <= data;
    request(2);
    wait_idle(pd);
    check(16'(control), 16'(data));
    check(16'(valid_cnt - v), 16'h0000);
  endtask
  task automatic do_read(input logic short, input logic [9:0] exp);
    logic pd;
    int   v;
    v = valid_cnt;
    @(posedge clk_sys_i);
    read_short <= short;
    request(1);
    wait_idle(pd);
    check(16'(rdata), 16'(exp));
    check(16'(valid_cnt - v), 16'h0001);
  endtask
  task automatic do_conv(input logic ap, input logic [9:0] smp,
                         input int exp_cyc);
    int   n;
    logic pd;
    n = 0;
    @(posedge clk_sys_i);
    auto_pd <= ap;
    sample  <= smp;
    request(0);
    while (link.busy !== 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      n++;
    end
    n = 0;
    while (link.busy === 1'b1 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(16'(n), 16'(exp_cyc));
    sample <= ~smp;
    wait_idle(pd);
    // Power-up follows the strobe rise through the synchroniser
    repeat (4) @(negedge clk_sys_i);
    check(16'(pd), 16'(ap));
    check(16'(normal), 16'(!ap));
    check(16'(pdown), 16'h0000);
  endtask
  initial begin
    resetn_i = 1'b0;
    tw = 1'b0;
    auto_pd = 1'b0;
    conv_req = 1'b0;
    read_req = 1'b0;
    read_short = 1'b0;
    write_req = 1'b0;
    wdata = 8'h00;
    sample = 10'h000;
    errors = 0;
    total_checks = 0;
    valid_cnt = 0;
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      tw <= i[0];
      do_write(i[0] ? 8'hc3 : 8'h20);
      do_conv(1'b0, 10'h2b5, acsp_pkg::CONV_ANALOG_CYC);
      do_read(1'b0, 10'h2b5);
      do_read(1'b1, 10'h0ad);
      // Temperature channel, second write straight after the reads
      do_write(8'h1f);
      do_conv(1'b1, 10'h14a, acsp_pkg::CONV_TEMP_CYC);
      do_read(1'b0, 10'h14a);
    end
    wrap_up();
  end
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_sys_i);
      cycles++;
      if (cycles == 20000) begin
        errors++;
        wrap_up();
      end
    end
  end
endmodule
